// ==== adc_amp_ref_control.sv ====
// converter, amplifier and reference control registers with conversion sequencer and interrupt
//
// Contract
// - reference-1 ground bit 0 selects digital ground, 1 selects negative reference pin.
// - reference-0 generator runs only while its enable bit is 1.
// - reference-0 supply bit 0 selects main supply, 1 positive reference pin.
// - reference-1 generator runs when its enable bit is 1, stopped otherwise.
// - conversion-complete flag sits at bit 0 of the flag register; 1 means pending.
// - conversion-complete interrupt is serviced only while its mask bit is 0.
// - conversions run while run bit 7 of mode register is 1; 0 stops. The code also needs comparator bit 0 at 1 to start or keep converting.
// - voltage comparator operates while bit 0 of mode register is 1.
// - amplifier runs while bit 7 of amplifier control is 1.
// - gain field bits 1 to 0 select x4, x8, x16, x32.
// - feedback ground bit 3 selects digital ground at 0, amplifier ground pin at 1.
`timescale 1ns/100ps
`default_nettype none
module adc_amp_ref_control
  import adc_ctrl_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output analog_ctrl_s     analog,
  output logic             conv_done,
  output logic             irq
);

  bus_req_s     bus_req;
  logic [7:0]   rd_addr;
  logic [31:0]  rdata;

  analog_ctrl_s ctl_reg;
  analog_ctrl_s ctl_next;
  logic         flag_reg;
  logic         flag_next;
  logic         mask_reg;
  logic         mask_next;
  logic         irq_reg;
  logic         irq_next;
  conv_state_e  state_reg;
  conv_state_e  state_next;
  logic [7:0]   cnt_reg;
  logic [7:0]   cnt_next;
  logic         done_reg;
  logic         done_next;
  logic [7:0]   busy_age_reg;
  logic [7:0]   busy_age_next;

  logic         wr_cvr;
  logic         wr_flag;
  logic         wr_mask;
  logic         wr_mode;
  logic         wr_amp;
  logic         conv_end;
  logic         flag_clear;

  // only whole-word transfers are expected, so the size is not decoded
  ahb_lite_slave u_bus (
    .mclk      (mclk),
    .nrst      (nrst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .rdata     (rdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_addr   (rd_addr),
    .bus_req   (bus_req)
  );

  always_comb
  begin
    rdata = RDATA_ZERO;
    case (rd_addr)
      OFS_CVR:
      begin
        rdata[BIT_REF1_ENABLE]     = ctl_reg.ref1_enable;
        rdata[BIT_REF1_GROUND_SEL] = ctl_reg.ref1_ground_sel;
        rdata[BIT_REF0_ENABLE]     = ctl_reg.ref0_enable;
        rdata[BIT_REF0_SUPPLY_SEL] = ctl_reg.ref0_supply_sel;
      end
      OFS_FLAG:  rdata[BIT_CONV_DONE] = flag_reg;
      OFS_MASK:  rdata[BIT_CONV_DONE] = mask_reg;
      OFS_MODE0:
      begin
        rdata[BIT_CONV_RUN]   = ctl_reg.conv_run;
        rdata[BIT_COMP_POWER] = ctl_reg.comparator_power;
      end
      OFS_AMP:
      begin
        rdata[BIT_AMP_ENABLE]    = ctl_reg.amp_enable;
        rdata[BIT_AMP_FB_GROUND] = ctl_reg.amp_feedback_ground_sel;
        rdata[BIT_GAIN_HI]       = ctl_reg.amp_gain_sel[1];
        rdata[BIT_GAIN_LO]       = ctl_reg.amp_gain_sel[0];
      end
      default:   rdata = RDATA_ZERO;
    endcase
  end

  always_comb
  begin
    wr_cvr  = bus_req.wr && (bus_req.addr == OFS_CVR);
    wr_flag = bus_req.wr && (bus_req.addr == OFS_FLAG);
    wr_mask = bus_req.wr && (bus_req.addr == OFS_MASK);
    wr_mode = bus_req.wr && (bus_req.addr == OFS_MODE0);
    wr_amp  = bus_req.wr && (bus_req.addr == OFS_AMP);
    ctl_next = ctl_reg;
    if (wr_cvr)
    begin
      ctl_next.ref1_ground_sel = bus_req.wdata[BIT_REF1_GROUND_SEL];
      ctl_next.ref0_enable     = bus_req.wdata[BIT_REF0_ENABLE];
      ctl_next.ref0_supply_sel = bus_req.wdata[BIT_REF0_SUPPLY_SEL];
      ctl_next.ref1_enable     = bus_req.wdata[BIT_REF1_ENABLE];
    end
    if (wr_mode)
    begin
      ctl_next.conv_run         = bus_req.wdata[BIT_CONV_RUN];
      ctl_next.comparator_power = bus_req.wdata[BIT_COMP_POWER];
    end
    if (wr_amp)
    begin
      ctl_next.amp_enable              = bus_req.wdata[BIT_AMP_ENABLE];
      ctl_next.amp_feedback_ground_sel = bus_req.wdata[BIT_AMP_FB_GROUND];
      ctl_next.amp_gain_sel            = bus_req.wdata[BIT_GAIN_HI:BIT_GAIN_LO];
    end
    // gain factor doubles per code step
    ctl_next.amp_gain_factor = GAIN_BASE << ctl_next.amp_gain_sel;
  end

  // conversion sequencer: back-to-back conversions of fixed length while enabled
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    conv_end   = 1'b0;
    case (state_reg)
      CONV_IDLE:
      begin
        cnt_next = 8'h00;
        // start only with the run bit set
        if (ctl_reg.conv_run && ctl_reg.comparator_power)
        begin
          state_next = CONV_BUSY;
        end
      end
      CONV_BUSY:
      begin
        // losing comparator power aborts the conversion
        if (!ctl_reg.conv_run || !ctl_reg.comparator_power)
        begin
          state_next = CONV_IDLE;
          cnt_next   = 8'h00;
        end
        else if (cnt_reg == CONV_LAST)
        begin
          conv_end = 1'b1;
          cnt_next = 8'h00;
        end
        else
        begin
          cnt_next = cnt_reg + 8'h01;
        end
      end
      default:
      begin
        state_next = CONV_IDLE;
        cnt_next   = 8'h00;
      end
    endcase
    done_next = conv_end;
  end

  always_comb
  begin
    // a new conversion end beats a same-cycle clear
    flag_clear = wr_flag && !bus_req.wdata[BIT_CONV_DONE];
    flag_next  = conv_end || (flag_reg && !flag_clear);
    mask_next  = wr_mask ? bus_req.wdata[BIT_CONV_DONE] : mask_reg;
    // mask of 1 blocks the request
    irq_next   = flag_next && !mask_next;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctl_reg   <= '{amp_gain_factor: GAIN_BASE, default: '0};
      flag_reg  <= 1'b0;
      mask_reg  <= RST_MASK;
      irq_reg   <= 1'b0;
      state_reg <= CONV_IDLE;
      cnt_reg   <= 8'h00;
      done_reg  <= 1'b0;
    end
    else
    begin
      ctl_reg   <= ctl_next;
      flag_reg  <= flag_next;
      mask_reg  <= mask_next;
      irq_reg   <= irq_next;
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      done_reg  <= done_next;
    end
  end

  assign analog    = ctl_reg;
  assign conv_done = done_reg;
  assign irq       = irq_reg;

  // age since entering busy, kept apart from the sequencer count so the timing check is independent
  always_comb
  begin
    busy_age_next = 8'h00;
    if (state_reg == CONV_BUSY && busy_age_reg != 8'hFF)
    begin
      busy_age_next = busy_age_reg + 8'h01;
    end
    else if (state_reg == CONV_BUSY)
    begin
      busy_age_next = busy_age_reg;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_age_reg <= 8'h00;
    end
    else
    begin
      busy_age_reg <= busy_age_next;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_ref1_ground_sel: assert property (wr_cvr |=> analog.ref1_ground_sel == $past(bus_req.wdata[4]))
    else $error("reference-1 ground select not taken from write");
  a_ref0_run_ctl: assert property (wr_cvr && !bus_req.wdata[2] |=> !analog.ref0_enable)
    else $error("reference-0 not stopped by write of 0");
  a_ref0_supply_sel: assert property (wr_cvr |=> analog.ref0_supply_sel == $past(bus_req.wdata[1]))
    else $error("reference-0 supply select not taken from write");
  a_ref1_run_ctl: assert property (!wr_cvr |=> $stable(analog.ref1_enable))
    else $error("reference-1 enable changed without a write");
  a_flag_readback: assert property (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && haddr[7:0] == OFS_FLAG
    |=> hrdata == {31'h0000_0000, $past(flag_reg)})
    else $error("flag register read does not show the flag");
  a_irq_masking: assert property (irq == (flag_reg && !mask_reg))
    else $error("interrupt output does not follow flag and mask");
  a_run_stop: assert property (!analog.conv_run |=> !conv_done ##1 !conv_done)
    else $error("conversion ended while the run bit was clear");
  a_conv_period: assert property (state_reg == CONV_BUSY && busy_age_reg == CONV_LAST
    && analog.conv_run && analog.comparator_power |=> conv_done)
    else $error("first conversion did not end after the conversion time");
  a_comp_power: assert property (!analog.comparator_power |=> !conv_done)
    else $error("conversion ended with the comparator stopped");
  a_amp_run_ctl: assert property (wr_amp |=> analog.amp_enable == $past(bus_req.wdata[7]))
    else $error("amplifier enable not taken from write");
  a_gain_decode: assert property (analog.amp_gain_factor == (analog.amp_gain_sel == 2'h0 ? 6'h04 :
    analog.amp_gain_sel == 2'h1 ? 6'h08 : analog.amp_gain_sel == 2'h2 ? 6'h10 : 6'h20))
    else $error("gain factor does not match gain code");
  a_fb_ground_sel: assert property (wr_amp |=> analog.amp_feedback_ground_sel == $past(bus_req.wdata[3]))
    else $error("feedback ground select not taken from write");
  a_flag_sticky: assert property (conv_done |-> flag_reg)
    else $error("conversion end did not set the flag");
  a_flag_hold: assert property (flag_reg && !(wr_flag && !bus_req.wdata[0]) |=> flag_reg)
    else $error("flag dropped without a clearing write");

endmodule : adc_amp_ref_control
`default_nettype wire

// ==== adc_amp_ref_control_tb.sv ====
// self-checking bench for the converter, amplifier and reference control block
`timescale 1ns/100ps
`default_nettype none
module adc_amp_ref_control_tb_top
  import adc_ctrl_pkg::*;
;
  logic         mclk;
  logic         nrst;
  logic         hsel;
  logic [31:0]  haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [2:0]   hsize;
  logic [31:0]  hwdata;
  logic         hready;
  logic         hreadyout;
  logic         hresp;
  logic [31:0]  hrdata;
  analog_ctrl_s analog;
  logic         conv_done;
  logic         irq;
  int           err_total = 0;
  int           checks_done = 0;
  int           pulses = 0;
  int           cycles = 0;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  adc_amp_ref_control dut (
    .mclk      (mclk),
    .nrst      (nrst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .analog    (analog),
    .conv_done (conv_done),
    .irq       (irq)
  );

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    if (conv_done === 1'b1)
      pulses <= pulses + 1;
    cycles <= cycles + 1;
    // generous ceiling, the whole run needs well under a thousand cycles
    if (cycles == 5000)
    begin
      err_total++;
      $display("[ERR] %0t timeout", $time);
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // address phase, then data phase; both held until ready is seen high
  task automatic xfer(input logic wr_en, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr_en;
    @(posedge mclk);
    while (hready !== 1'b1)
      @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge mclk);
    while (hready !== 1'b1)
      @(posedge mclk);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(1'b1, a, d, dummy);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    xfer(1'b0, a, 32'h0000_0000, d);
    chk(d, exp, what);
  endtask : rchk

  // every run bit write is preceded by the flag clear and mask clear
  task automatic run_ctl(input logic [31:0] mode);
    wr(OFS_FLAG, 32'h0000_0000);
    wr(OFS_MASK, 32'h0000_0000);
    wr(OFS_MODE0, mode);
  endtask : run_ctl

  // let the write land in the register and reach the outputs
  task automatic settle();
    @(negedge mclk);
  endtask : settle

  task automatic wait_done(output int n);
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (conv_done !== 1'b1 && n < 200);
    if (conv_done !== 1'b1)
    begin
      err_total++;
      $display("[ERR] %0t no conversion end", $time);
    end
  endtask : wait_done

  initial
  begin
    int bpos[4];
    int n;
    int p;
    bpos = '{5, 4, 2, 1};
    nrst   = 1'b0;
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = 32'h0000_0000;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    settle();
    chk(irq, 1'b0, "irq after reset");
    chk(analog.amp_gain_factor, 32'h0000_0004, "gain after reset");
    rchk(OFS_CVR, 32'h0000_0000, "cvr reset");
    rchk(OFS_FLAG, 32'h0000_0000, "flag reset");
    rchk(OFS_MASK, 32'h0000_0001, "mask reset");
    rchk(OFS_MODE0, 32'h0000_0000, "mode reset");
    rchk(OFS_AMP, 32'h0000_0000, "amp reset");
    $display("test reset_values done");

    for (int i = 0; i < 4; i++)
    begin
      // shared reference pins never serve as comparator-one inputs here
      wr(OFS_CVR, 32'h0000_0001 << bpos[i]);
      settle();
      chk({analog.ref1_enable, analog.ref1_ground_sel, analog.ref0_enable, analog.ref0_supply_sel},
          32'h0000_0008 >> i, "reference field");
    end
    wr(OFS_CVR, 32'h0000_00FF);
    rchk(OFS_CVR, 32'h0000_0036, "cvr reserved bits");
    wr(8'h14, 32'h0000_00FF);
    rchk(8'h14, 32'h0000_0000, "unmapped read");
    $display("test references done");

    for (int g = 0; g < 4; g++)
    begin
      wr(OFS_AMP, 32'h0000_0080 | ((g & 1) << 3) | g);
      settle();
      chk(analog.amp_gain_factor, 32'h0000_0004 << g, "gain factor");
      chk(analog.amp_gain_sel, g, "gain select");
      chk(analog.amp_enable, 1'b1, "amp enable");
      chk(analog.amp_feedback_ground_sel, g & 1, "feedback ground");
    end
    wr(OFS_AMP, 32'h0000_00FF);
    rchk(OFS_AMP, 32'h0000_008B, "amp reserved bits");
    wr(OFS_AMP, 32'h0000_0000);
    settle();
    chk(analog.amp_enable, 1'b0, "amp stop");
    $display("test amplifier done");

    run_ctl(32'h0000_0081);
    settle();
    chk({analog.conv_run, analog.comparator_power}, 32'h0000_0003, "mode fields");
    wait_done(n);
    wait_done(n);
    chk(n, CONV_CYCLES_I, "conversion period");
    chk(irq, 1'b1, "irq unmasked");
    rchk(OFS_FLAG, 32'h0000_0001, "flag pending");
    wr(OFS_MASK, 32'h0000_0001);
    settle();
    chk(irq, 1'b0, "irq masked");
    rchk(OFS_FLAG, 32'h0000_0001, "flag held under mask");
    wr(OFS_FLAG, 32'h0000_0001);
    rchk(OFS_FLAG, 32'h0000_0001, "write one keeps flag");
    // stop just after a conversion end so none lands between the clear and the stop
    wait_done(n);
    run_ctl(32'h0000_0001);
    p = pulses;
    repeat (45) @(posedge mclk);
    chk(pulses, p, "run stopped");
    rchk(OFS_FLAG, 32'h0000_0000, "write zero clears flag");
    $display("test conversion done");

    run_ctl(32'h0000_0080);
    p = pulses;
    repeat (45) @(posedge mclk);
    chk(pulses, p, "comparator off");
    rchk(OFS_FLAG, 32'h0000_0000, "no flag without comparator");
    run_ctl(32'h0000_0081);
    wr(OFS_MASK, 32'h0000_0001);
    wait_done(n);
    chk(irq, 1'b0, "masked conversion");
    rchk(OFS_FLAG, 32'h0000_0001, "flag set while masked");
    run_ctl(32'h0000_0000);
    $display("test comparator_and_mask done");
    complete_run();
  end
endmodule : adc_amp_ref_control_tb_top
`default_nettype wire

// ==== adc_ctrl_pkg.sv ====
// shared constants, register map and carrier types for the converter control block
package adc_ctrl_pkg;

  // byte offsets of the word-aligned registers
  localparam logic [7:0] OFS_CVR   = 8'h00;
  localparam logic [7:0] OFS_FLAG  = 8'h04;
  localparam logic [7:0] OFS_MASK  = 8'h08;
  localparam logic [7:0] OFS_MODE0 = 8'h0C;
  localparam logic [7:0] OFS_AMP   = 8'h10;

  // comparator_reference_control fields
  localparam int BIT_REF1_ENABLE     = 5;
  localparam int BIT_REF1_GROUND_SEL = 4;
  localparam int BIT_REF0_ENABLE     = 2;
  localparam int BIT_REF0_SUPPLY_SEL = 1;
  // interrupt flag and mask fields
  localparam int BIT_CONV_DONE       = 0;
  // converter_mode_zero fields
  localparam int BIT_CONV_RUN        = 7;
  localparam int BIT_COMP_POWER      = 0;
  // gain_amplifier_control fields
  localparam int BIT_AMP_ENABLE      = 7;
  localparam int BIT_AMP_FB_GROUND   = 3;
  localparam int BIT_GAIN_HI         = 1;
  localparam int BIT_GAIN_LO         = 0;

  // reset values, transfer type code and default read data
  localparam logic       RST_MASK        = 1'b1;
  localparam logic [5:0] GAIN_BASE       = 6'h04;
  localparam logic [1:0] HTRANS_NONSEQ   = 2'b10;
  localparam logic [31:0] RDATA_ZERO     = 32'h0000_0000;

  // conversion timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_TIME_NS  = 1000;
  localparam int CONV_CYCLES_I = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES_I - 1);

  typedef enum logic {CONV_IDLE, CONV_BUSY} conv_state_e;

  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic       ref1_enable;
    logic       ref1_ground_sel;
    logic       ref0_enable;
    logic       ref0_supply_sel;
    logic       conv_run;
    logic       comparator_power;
    logic       amp_enable;
    logic       amp_feedback_ground_sel;
    logic [1:0] amp_gain_sel;
    logic [5:0] amp_gain_factor;
  } analog_ctrl_s;

endpackage : adc_ctrl_pkg

// ==== ahb_lite_slave.sv ====
// zero-wait ahb-lite slave front end: address capture, write strobe, registered read data
`timescale 1ns/100ps
`default_nettype none
module ahb_lite_slave
  import adc_ctrl_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] rdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic [7:0]       rd_addr,
  output bus_req_s         bus_req
);

  logic        wr_pend_reg;
  logic        wr_pend_next;
  logic [7:0]  wr_addr_reg;
  logic [7:0]  wr_addr_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic        active;

  always_comb
  begin
    active       = hsel && hready && (htrans == HTRANS_NONSEQ);
    wr_pend_next = active && hwrite;
    wr_addr_next = active ? haddr[7:0] : wr_addr_reg;
    // read data is fetched at the address edge so the data phase needs no wait
    hrdata_next  = (active && !hwrite) ? rdata : RDATA_ZERO;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg  <= hrdata_next;
    end
  end

  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = hrdata_reg;
  assign rd_addr       = haddr[7:0];
  assign bus_req.wr    = wr_pend_reg;
  assign bus_req.addr  = wr_addr_reg;
  assign bus_req.wdata = hwdata;

endmodule : ahb_lite_slave
`default_nettype wire
